// ### core/tef_map.vh
/*
 Register map, field positions and codes of the timer event flag block.
 Assumes inclusion by the design files of this block only.
*/
`ifndef TEF_MAP_VH
`define TEF_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TEF_OFS_EN 12'h00c
`define TEF_OFS_STS 12'h010
`define TEF_OFS_GEN 12'h014

// ----------------------------------------
// Enable register fields
// ----------------------------------------
`define TEF_EN_UIE 0
`define TEF_EN_CIE_LO 1
`define TEF_EN_TIE 6
`define TEF_EN_UDE 8
`define TEF_EN_CDE_LO 9
`define TEF_EN_TDE 14
`define TEF_EN_MASK 16'h5f5f
`define TEF_EN_RST 16'h0000

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define TEF_ST_UIF 0
`define TEF_ST_CIF_LO 1
`define TEF_ST_TIF 6
`define TEF_ST_OCF_LO 9
`define TEF_ST_RST 16'h0000

// ----------------------------------------
// Event generation fields
// ----------------------------------------
`define TEF_GEN_UG 0
`define TEF_GEN_CG_LO 1
`define TEF_GEN_TG 6

// ----------------------------------------
// Slave mode and alignment codes
// ----------------------------------------
`define TEF_SM_RESET 3'h4
`define TEF_SM_GATED 3'h5
`define TEF_CA_EDGE 2'h0
`define TEF_CA_DOWN 2'h1
`define TEF_CA_UP 2'h2

`endif

// ### core/tef_chan.v
/*
 One capture/compare channel: event flag and overcapture flag.
 Assumes strobes are one-cycle pulses synchronous to sys_clk_i.
*/
`timescale 1ns/1ps
`include "tef_map.vh"

module tef_chan (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // Channel mode and counter events
  input wire input_mode_i,
  input wire match_i,
  input wire cmp_above_arr_i,
  input wire overflow_i,
  input wire underflow_i,
  input wire count_down_i,
  input wire [1:0] center_align_select_i,
  input wire capture_i,
  input wire sw_gen_i,
  input wire cap_read_i,
  // Software status write
  input wire sts_wr_i,
  input wire flag_wbit_i,
  input wire over_wbit_i,
  // Flags and event pulse
  output reg event_flag_o,
  output reg over_flag_o,
  output wire event_o
);

  reg match_ok;
  reg wrap_ok;
  wire out_evt;
  wire cap_evt;

  // ----------------------------------------
  // Compare qualification
  // ----------------------------------------
  // Center modes 1 and 2 only flag matches in the chosen counting direction
  always @* begin
    case (center_align_select_i)
      `TEF_CA_EDGE: match_ok = 1'b1;
      `TEF_CA_DOWN: match_ok = count_down_i;
      `TEF_CA_UP: match_ok = ~count_down_i;
      default: match_ok = 1'b1;
    endcase
    // wrap with large compare
    // Only edge-aligned down counting wraps through underflow
    if (center_align_select_i == `TEF_CA_EDGE && count_down_i) begin
      wrap_ok = underflow_i;
    end else begin
      wrap_ok = overflow_i;
    end
  end

  assign out_evt = ~input_mode_i & ((match_i & match_ok) | (cmp_above_arr_i & wrap_ok) | sw_gen_i);
  assign cap_evt = input_mode_i & (capture_i | sw_gen_i);
  assign event_o = out_evt | cap_evt;

  // ----------------------------------------
  // Flags: a set always beats a clear
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      event_flag_o <= 1'b0;
      over_flag_o <= 1'b0;
    end else begin
      if (event_o) begin
        event_flag_o <= 1'b1;
      end else if ((sts_wr_i & ~flag_wbit_i) | (cap_read_i & input_mode_i)) begin
        event_flag_o <= 1'b0;
      end
      if (cap_evt & event_flag_o) begin
        over_flag_o <= 1'b1;
      end else if (sts_wr_i & ~over_wbit_i) begin
        over_flag_o <= 1'b0;
      end
    end
  end

endmodule // tef_chan

// ### core/tef_top.v
/*
 Timer event flags with interrupt and DMA request gating, APB slave.
 Assumes counter, slave controller and channel datapaths outside;
 their event strobes are one-cycle pulses on sys_clk_i.
*/
//
// Function
// - Trigger DMA request only when trigger DMA enable bit 14 is one.
// - Channels 1-4 have DMA enables at bits 9-12 gating their requests.
// - Update DMA request only when update DMA enable bit 8 is one.
// - Interrupt enables: trigger bit 6, channels bits 1-4, update bit 0.
// - Overcapture flag set on input capture while capture flag still set.
// - Flags set by hardware; writing zero clears a flag.
// - Trigger flag set on active trigger edge outside gated mode.
// - Output channel flag set on counter match, honouring center alignment.
// - Compare above reload flags on overflow, or underflow when edge-aligned counting down.
// - Update flag set on overflow or underflow when updates not disabled.
// - Software update request sets update flag when source and disable zero.
// - Slave reinit trigger sets update flag under the same condition.
// - Flags stay set until cleared; only capture read clears in hardware.
// - Gated mode counts only while trigger input high, stops without reset.
// - Software trigger request sets trigger flag, self clears.
`timescale 1ns/1ps
`include "tef_map.vh"

module tef_top (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Counter configuration
  input wire update_event_disable_i,
  input wire update_request_source_sel_i,
  input wire [1:0] center_align_select_i,
  input wire count_down_i,
  input wire [2:0] slave_mode_select_i,
  // Counter and trigger events
  input wire cnt_overflow_i,
  input wire cnt_underflow_i,
  input wire slave_trigger_input_i,
  // Channel events
  input wire [3:0] chan_input_mode_i,
  input wire [3:0] chan_match_i,
  input wire [3:0] chan_cmp_above_arr_i,
  input wire [3:0] chan_capture_i,
  input wire [3:0] chan_capture_read_i,
  // Requests out
  output reg irq_o,
  output reg update_dma_req_o,
  output reg [3:0] chan_dma_req_o,
  output reg trigger_dma_req_o,
  // Counter control out
  output reg count_gate_o,
  output reg counter_reinit_o,
  output reg [3:0] chan_sw_capture_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [15:0] en_r;
  reg update_flag_r;
  reg trig_flag_r;
  reg trig_prev_r;
  reg [31:0] rdata_nxt;
  reg rdec_ok;
  reg [15:0] sts_rd;
  wire acc;
  wire wr_do;
  wire en_wr;
  wire sts_wr;
  wire gen_wr;
  wire [3:0] chan_flag;
  wire [3:0] chan_over;
  wire [3:0] chan_evt;
  wire [3:0] chan_gen;
  wire [3:0] chan_ie;
  wire [3:0] chan_de;
  wire trig_rise;
  wire trig_fall;
  wire gated;
  wire trig_hw;
  wire sw_trig;
  wire sw_upd;
  wire trig_evt;
  wire slave_reinit;
  wire upd_src_ok;
  wire upd_evt;
  wire irq_nxt;

  // ----------------------------------------
  // Timing overview
  // ----------------------------------------
  // APB: setup cycle, one wait cycle, then pready_o for one cycle.
  // Read data is captured in the wait cycle, so prdata_o already
  // stands when pready_o rises; a write lands at the pready_o edge.
  // Events: a strobe seen at one edge sets its flag there; the DMA
  // pulse starts at that same edge and the interrupt level one cycle later.
  // The trigger input is taken as synchronous; an asynchronous source
  // needs a synchroniser outside, or false edges will set the flag.
  // A set beats a same-cycle clear, so an event racing a software
  // clear is never lost; software sees it on its next read.

  // ----------------------------------------
  // APB access decode
  // ----------------------------------------
  // Access phase, first cycle waits, second completes
  assign acc = psel_i & penable_i;
  // Writes land only at the completing edge
  assign wr_do = acc & pready_o & pwrite_i;
  assign en_wr = wr_do & (paddr_i == `TEF_OFS_EN);
  assign sts_wr = wr_do & (paddr_i == `TEF_OFS_STS);
  assign gen_wr = wr_do & (paddr_i == `TEF_OFS_GEN);

  // Status word, reserved bits read zero
  always @* begin
    sts_rd = 16'h0000;
    sts_rd[`TEF_ST_UIF] = update_flag_r;
    sts_rd[`TEF_ST_CIF_LO +: 4] = chan_flag;
    sts_rd[`TEF_ST_TIF] = trig_flag_r;
    sts_rd[`TEF_ST_OCF_LO +: 4] = chan_over;
  end

  // Read mux; generation register reads zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    rdec_ok = 1'b1;
    case (paddr_i)
      `TEF_OFS_EN: rdata_nxt = {16'h0000, en_r};
      `TEF_OFS_STS: rdata_nxt = {16'h0000, sts_rd};
      `TEF_OFS_GEN: rdata_nxt = 32'h0000_0000;
      default: rdec_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // APB response registers
  // ----------------------------------------
  // One wait state keeps the read mux off the pready path
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~rdec_ok;
      if (acc & ~pready_o & ~pwrite_i) begin
        prdata_o <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------
  // Enable register
  // ----------------------------------------
  // reserved bits held at zero
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_r <= `TEF_EN_RST;
    end else if (en_wr) begin
      en_r <= pwdata_i[15:0] & `TEF_EN_MASK;
    end
  end

  assign chan_ie = en_r[`TEF_EN_CIE_LO +: 4];
  assign chan_de = en_r[`TEF_EN_CDE_LO +: 4];

  // ----------------------------------------
  // Software event generation
  // ----------------------------------------
  // self clearing request bits
  assign sw_trig = gen_wr & pwdata_i[`TEF_GEN_TG];
  assign sw_upd = gen_wr & pwdata_i[`TEF_GEN_UG];
  assign chan_gen = {4{gen_wr}} & pwdata_i[`TEF_GEN_CG_LO +: 4];

  // ----------------------------------------
  // Trigger input edges
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= slave_trigger_input_i;
    end
  end

  assign trig_rise = slave_trigger_input_i & ~trig_prev_r;
  assign trig_fall = ~slave_trigger_input_i & trig_prev_r;
  assign gated = (slave_mode_select_i == `TEF_SM_GATED);
  assign trig_hw = gated ? (trig_rise | trig_fall) : trig_rise;
  assign trig_evt = trig_hw | sw_trig;
  // Reset mode reinitialises the counter on the rising edge
  assign slave_reinit = (slave_mode_select_i == `TEF_SM_RESET) & trig_rise;

  // ----------------------------------------
  // Update event qualification
  // ----------------------------------------
  assign upd_src_ok = ~update_request_source_sel_i & ~update_event_disable_i;
  assign upd_evt = (~update_event_disable_i & (cnt_overflow_i | cnt_underflow_i))
                 | (upd_src_ok & sw_upd)
                 | (upd_src_ok & slave_reinit);

  // ----------------------------------------
  // Update and trigger flags
  // ----------------------------------------
  // set wins, write zero clears
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      update_flag_r <= 1'b0;
      trig_flag_r <= 1'b0;
    end else begin
      if (upd_evt) begin
        update_flag_r <= 1'b1;
      end else if (sts_wr & ~pwdata_i[`TEF_ST_UIF]) begin
        update_flag_r <= 1'b0;
      end
      if (trig_evt) begin
        trig_flag_r <= 1'b1;
      end else if (sts_wr & ~pwdata_i[`TEF_ST_TIF]) begin
        trig_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Capture/compare channels
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      tef_chan u_chan (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .input_mode_i(chan_input_mode_i[gi]),
        .match_i(chan_match_i[gi]),
        .cmp_above_arr_i(chan_cmp_above_arr_i[gi]),
        .overflow_i(cnt_overflow_i),
        .underflow_i(cnt_underflow_i),
        .count_down_i(count_down_i),
        .center_align_select_i(center_align_select_i),
        .capture_i(chan_capture_i[gi]),
        .sw_gen_i(chan_gen[gi]),
        .cap_read_i(chan_capture_read_i[gi]),
        .sts_wr_i(sts_wr),
        .flag_wbit_i(pwdata_i[`TEF_ST_CIF_LO + gi]),
        .over_wbit_i(pwdata_i[`TEF_ST_OCF_LO + gi]),
        .event_flag_o(chan_flag[gi]),
        .over_flag_o(chan_over[gi]),
        .event_o(chan_evt[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Interrupt level
  // ----------------------------------------
  // per source gating
  assign irq_nxt = (update_flag_r & en_r[`TEF_EN_UIE])
                 | (|(chan_flag & chan_ie))
                 | (trig_flag_r & en_r[`TEF_EN_TIE]);

  // ----------------------------------------
  // Request outputs
  // ----------------------------------------
  // interrupt level register
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_nxt;
    end
  end

  // Registered, so each DMA pulse lags its event by one cycle
  // update DMA gate
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      update_dma_req_o <= 1'b0;
    end else begin
      update_dma_req_o <= upd_evt & en_r[`TEF_EN_UDE];
    end
  end

  // Each event pulses again even while its flag is still set
  // channel DMA gates
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chan_dma_req_o <= 4'h0;
    end else begin
      chan_dma_req_o <= chan_evt & chan_de;
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trigger_dma_req_o <= 1'b0;
    end else begin
      trigger_dma_req_o <= trig_evt & en_r[`TEF_EN_TDE];
    end
  end

  // ----------------------------------------
  // Counter control
  // ----------------------------------------
  // Gate follows the trigger level; counter value is untouched here
  // gated counting
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_gate_o <= 1'b1;
    end else begin
      count_gate_o <= gated ? slave_trigger_input_i : 1'b1;
    end
  end

  // Reinit pulse for a software update or a reset-mode trigger
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      counter_reinit_o <= 1'b0;
    end else begin
      counter_reinit_o <= sw_upd | slave_reinit;
    end
  end

  // Software capture only reaches channels in input mode
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chan_sw_capture_o <= 4'h0;
    end else begin
      chan_sw_capture_o <= chan_gen & chan_input_mode_i;
    end
  end

endmodule // tef_top

// ### testbench/tef_top_assertions.sv
/* Checker for tef_top: APB timing, reserved read bits and request causes.
   Assumes it is bound to tef_top and sees only its ports. */
`timescale 1ns/1ps
module tef_top_chk (
  // Clock, reset and APB
  input wire sys_clk_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Events and outputs
  input wire update_event_disable_i,
  input wire [2:0] slave_mode_select_i,
  input wire slave_trigger_input_i,
  input wire [3:0] chan_capture_read_i,
  input wire irq_o,
  input wire update_dma_req_o,
  input wire trigger_dma_req_o,
  input wire count_gate_o,
  input wire counter_reinit_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire wr_done = psel_i & penable_i & pwrite_i & pready_o;
  wire mapped = paddr_i == 12'h00c || paddr_i == 12'h010 || paddr_i == 12'h014;
  wire [31:0] resv = paddr_i == 12'h010 ? 32'hffffe1a0 : 32'hffffa0a0;
  logic t1, t2, t3, w1, c1, c2;
  // Delayed copies; internal edge detect may lag one cycle
  always @(posedge sys_clk_i) begin
    t1 <= slave_trigger_input_i;
    t2 <= t1;
    t3 <= t2;
    w1 <= wr_done;
    c1 <= wr_done | (|chan_capture_read_i);
    c2 <= c1;
  end
  apb_wait_a: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("ready not in second access cycle");
  ready_once_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  slverr_map_a: assert property (pready_o |-> pslverr_o == !mapped)
    else $error("error response mismatch");
  rd_resv_a: assert property (pready_o && !pwrite_i |-> (prdata_o & resv) == 0)
    else $error("reserved read bits set");
  upd_dis_a: assert property (update_dma_req_o |-> !$past(update_event_disable_i))
    else $error("update request while disabled");
  trg_cause_a: assert property (trigger_dma_req_o |-> w1 || t1 != t2 || t2 != t3)
    else $error("trigger request without trigger");
  reinit_cause_a: assert property (counter_reinit_o |-> w1 || t1 && !t2 || t2 && !t3)
    else $error("reinit without cause");
  irq_drop_a: assert property ($fell(irq_o) |-> c1 || c2 || $past(c2))
    else $error("interrupt dropped without clear");
  gate_free_a: assert property (slave_mode_select_i != 3'h5 &&
    $past(slave_mode_select_i) != 3'h5 |-> count_gate_o)
    else $error("gate low outside gated mode");
  gate_follow_a: assert property (slave_mode_select_i == 3'h5 &&
    $past(slave_mode_select_i) == 3'h5 && t1 == t2 && t2 == t3 |-> count_gate_o == t1)
    else $error("gate does not follow trigger");
endmodule // tef_top_chk

bind tef_top tef_top_chk i_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o),
  .update_event_disable_i(update_event_disable_i),
  .slave_mode_select_i(slave_mode_select_i), .slave_trigger_input_i(slave_trigger_input_i),
  .chan_capture_read_i(chan_capture_read_i), .irq_o(irq_o),
  .update_dma_req_o(update_dma_req_o), .trigger_dma_req_o(trigger_dma_req_o),
  .count_gate_o(count_gate_o), .counter_reinit_o(counter_reinit_o));

// ### testbench/tef_req_sink.sv
/* Request sink standing in for the DMA controller and the counter and channel datapaths.
   Assumes request outputs are one-cycle pulses on sys_clk_i. */
`timescale 1ns/1ps
module tef_req_sink (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // Request pulses
  input wire upd_i,
  input wire [3:0] chan_i,
  input wire trg_i,
  input wire reinit_i,
  input wire [3:0] swcap_i,
  // Pulse counts
  output integer n_ev_o [0:7]
);
  // one count per pulse
  // A stuck request shows up as an over-count, an unknown one as x
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int k = 0; k < 8; k++) n_ev_o[k] <= 0;
    end else begin
      n_ev_o[0] <= n_ev_o[0] + upd_i;
      for (int k = 0; k < 4; k++) n_ev_o[k+1] <= n_ev_o[k+1] + chan_i[k];
      n_ev_o[5] <= n_ev_o[5] + trg_i;
      n_ev_o[6] <= n_ev_o[6] + reinit_i;
      n_ev_o[7] <= n_ev_o[7] + (|swcap_i);
    end
  end
endmodule // tef_req_sink

// ### testbench/tef_top_test.sv
/* Self-checking bench for tef_top with an integer model of the flags.
   Assumes the checker is bound and tef_req_sink counts requests. */
`timescale 1ns/1ps
`define CMP(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tef_top_test;
  logic sys_clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, perr;
  logic update_event_disable_i = 0, update_request_source_sel_i = 0;
  logic count_down_i = 0, slave_trigger_input_i = 0;
  logic [1:0] center_align_select_i = 0;
  logic [2:0] slave_mode_select_i = 0;
  logic [3:0] chan_input_mode_i = 0, chan_cmp_above_arr_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rd;
  logic [13:0] ev = 0;
  wire cnt_overflow_i = ev[0];
  wire cnt_underflow_i = ev[1];
  wire [3:0] chan_match_i = ev[5:2];
  wire [3:0] chan_capture_i = ev[9:6];
  wire [3:0] chan_capture_read_i = ev[13:10];
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, irq_o, update_dma_req_o, trigger_dma_req_o;
  wire count_gate_o, counter_reinit_o;
  wire [3:0] chan_dma_req_o, chan_sw_capture_o;
  int n_errors = 0, samples_checked = 0, st = 0, en = 0, xd [0:7];
  integer n_ev [0:7];

  tef_top i_dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .update_event_disable_i(update_event_disable_i),
    .update_request_source_sel_i(update_request_source_sel_i),
    .center_align_select_i(center_align_select_i), .count_down_i(count_down_i),
    .slave_mode_select_i(slave_mode_select_i), .cnt_overflow_i(cnt_overflow_i),
    .cnt_underflow_i(cnt_underflow_i), .slave_trigger_input_i(slave_trigger_input_i),
    .chan_input_mode_i(chan_input_mode_i), .chan_match_i(chan_match_i),
    .chan_cmp_above_arr_i(chan_cmp_above_arr_i), .chan_capture_i(chan_capture_i),
    .chan_capture_read_i(chan_capture_read_i), .irq_o(irq_o),
    .update_dma_req_o(update_dma_req_o), .chan_dma_req_o(chan_dma_req_o),
    .trigger_dma_req_o(trigger_dma_req_o), .count_gate_o(count_gate_o),
    .counter_reinit_o(counter_reinit_o), .chan_sw_capture_o(chan_sw_capture_o));
  tef_req_sink i_sink (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .upd_i(update_dma_req_o),
    .chan_i(chan_dma_req_o), .trg_i(trigger_dma_req_o), .reinit_i(counter_reinit_o),
    .swcap_i(chan_sw_capture_o), .n_ev_o(n_ev));

  always #10 sys_clk_i = ~sys_clk_i;

  // APB transfer; answer taken at the edge that samples pready_o high
  task apb(input bit w, input [11:0] a, input [31:0] d, output [31:0] r);
    @(posedge sys_clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    perr = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    logic [31:0] x;
    apb(1, a, d, x);
  endtask
  // One-cycle event strobes
  task pulse(input [13:0] v);
    @(posedge sys_clk_i);
    ev <= v;
    @(posedge sys_clk_i);
    ev <= 0;
  endtask
  // Model: s marks software or slave update sources
  task m_upd(input bit s);
    if (!update_event_disable_i && !(s && update_request_source_sel_i)) begin
      st |= 1;
      xd[0] += en[8];
    end
  endtask
  task m_trg;
    st |= 'h40;
    xd[5] += en[14];
  endtask
  task m_ch(input int i);
    if (chan_input_mode_i[i] && st[i+1]) st |= 1 << (9 + i);
    st |= 1 << (i + 1);
    xd[1+i] += en[9+i];
  endtask
  task trg(input bit v);
    @(posedge sys_clk_i);
    slave_trigger_input_i <= v;
    repeat (3) @(posedge sys_clk_i);
    if (v || slave_mode_select_i == 3'h5) m_trg;
    if (v && slave_mode_select_i == 3'h4) begin
      xd[6]++;
      m_upd(1);
    end
    `CMP("gate", slave_mode_select_i != 3'h5 || v, count_gate_o)
  endtask
  task chk(input string s);
    logic [31:0] r;
    apb(0, 12'h010, 0, r);
    `CMP(s, st, r)
    `CMP("irq", |(st & en & 'h5f), irq_o)
    for (int k = 0; k < 8; k++) `CMP("requests", xd[k], n_ev[k])
  endtask
  task results;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    results;
  end

  initial begin
    rd = $urandom(32'h19d0d7c9);
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1;
    apb(0, 12'h00c, 0, rd);
    `CMP("enable reset", 0, rd)
    apb(0, 12'h014, 0, rd);
    `CMP("gen read", 0, rd)
    apb(1, 12'h020, 1, rd);
    `CMP("unmapped", 1'b1, perr)
    chk("reset");
    $display("test reset done");
    // Each round varies mode, alignment, sources and enables
    for (int p = 0; p < 6; p++) begin
      @(posedge sys_clk_i);
      update_event_disable_i <= p == 1;
      update_request_source_sel_i <= p == 2;
      slave_mode_select_i <= p == 3 ? 3'h5 : p == 4 ? 3'h4 : 3'h0;
      chan_input_mode_i <= {4{p[0]}};
      center_align_select_i <= p[2:1];
      chan_cmp_above_arr_i <= p[0] ? 4'h0 : 4'hf;
      count_down_i <= !p[0];
      en = $urandom & (p == 1 || p == 2 ? 'h5e5f : 'h5f5f);
      wr(12'h00c, en);
      apb(0, 12'h00c, 0, rd);
      `CMP("enable", en, rd)
      pulse(14'h1);
      m_upd(0);
      if (!p[0] && (center_align_select_i != 2'h0 || !count_down_i))
        for (int i = 0; i < 4; i++) m_ch(i);
      pulse(14'h2);
      m_upd(0);
      if (!p[0] && center_align_select_i == 2'h0 && count_down_i)
        for (int i = 0; i < 4; i++) m_ch(i);
      wr(12'h014, 1);
      xd[6]++;
      m_upd(1);
      trg(1);
      trg(0);
      wr(12'h014, 'h40);
      m_trg;
      for (int i = 0; i < 4; i++) begin
        pulse(p[0] ? 14'h40 << i : 14'h4 << i);
        if (p[0] || center_align_select_i == 2'h0 || center_align_select_i == 2'h3 ||
            center_align_select_i[0] == count_down_i) m_ch(i);
        wr(12'h014, 2 << i);
        m_ch(i);
        xd[7] += p[0];
      end
      chk("events");
      pulse(14'h3c00);
      if (p[0]) st &= ~'h1e;
      chk("capture read");
      rd = $urandom & 'h1e5f;
      wr(12'h010, rd);
      st &= rd;
      chk("partial clear");
      wr(12'h010, 0);
      st = 0;
      chk("full clear");
      $display("test round %0d done", p);
    end
    results;
  end
endmodule // tef_top_test
